// ### fault_mask_and_clear_regs.svh
// register map, field positions and reset values of the fault mask and clear block
// assumes an 8-bit register port with 12-bit byte addresses
`ifndef FAULT_MASK_AND_CLEAR_REGS_SVH
`define FAULT_MASK_AND_CLEAR_REGS_SVH

`define FMC_ADDR_W 12
`define FMC_DATA_W 8

`define FMC_OFS_MASK_PRIMARY 12'h016
`define FMC_OFS_MASK_SECONDARY 12'h017
`define FMC_OFS_CLEAR_PRIMARY 12'h331
`define FMC_OFS_CLEAR_SECONDARY 12'h332
`define FMC_OFS_ALARM_SUMMARY 12'h52D
`define FMC_OFS_IRQ_STATUS 12'h600
`define FMC_OFS_IRQ_MASK 12'h601

`define FMC_RST_MASK_PRIMARY 8'h00
`define FMC_RST_MASK_SECONDARY 8'h00
`define FMC_RST_CLEAR 8'h00
`define FMC_RST_IRQ_STATUS 8'h00
`define FMC_RST_IRQ_STATUS_BIT 1'h0
`define FMC_RST_IRQ_MASK 8'h00
`define FMC_RST_READ_DATA 8'h00

// primary mask / primary clear
`define FMC_P_GUARD 7
`define FMC_P_UNDERTEMP 6
`define FMC_P_OVERTEMP 5
`define FMC_P_UNDERVOLT 4
`define FMC_P_OVERVOLT 3
`define FMC_P_ADC_COMPARE 2
`define FMC_P_SYSTEM 1
`define FMC_P_RAIL 0

// secondary mask / secondary clear
`define FMC_S_SPARE 7
`define FMC_S_OTMEM_CRC 6
`define FMC_S_OTMEM_DATA 5
`define FMC_S_FAULT_LINK 4
`define FMC_S_FAULT_TONE 3
`define FMC_S_HEARTBEAT 2
`define FMC_S_CHAIN_LINK 1
`define FMC_S_UART_LINK 0

// writable bits: secondary clear bit 7 is reserved
`define FMC_CLEAR_PRIMARY_BITS 8'hFF
`define FMC_CLEAR_SECONDARY_BITS 8'h7F

// alarm summary and interrupt status layout
`define FMC_SUM_GUARD 7
`define FMC_SUM_ADC_COMPARE 6
`define FMC_SUM_OTMEM 5
`define FMC_SUM_LINK 4
`define FMC_SUM_TEMP 3
`define FMC_SUM_VOLT 2
`define FMC_SUM_SYSTEM 1
`define FMC_SUM_RAIL 0

`endif

// ### fault_mask_and_clear_pkg.sv
// types shared by the fault mask and clear block
// assumes the widths of fault_mask_and_clear_regs.svh
`include "fault_mask_and_clear_regs.svh"
package fault_mask_and_clear_pkg;
  typedef logic [`FMC_ADDR_W-1:0] reg_addr_type;
  typedef logic [`FMC_DATA_W-1:0] reg_byte_type;
endpackage

// ### fault_mask_and_clear.sv
// fault aggregation: masks, write-one clears, alarm pin, summary, interrupt
// assumes fault status owners on the same clock give "any bit set" levels
// and clear their registers on the one-cycle clear pulses driven here
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`include "fault_mask_and_clear_regs.svh"

// What this block does
// - Guard, undervolt, overvolt and adc compare faults pull the alarm pin low unless masked.
// - System faults pull the alarm pin low while the system mask bit is 0.
// - The otmem crc mask gates only the customer and factory crc flags onto the pin.
// - The otmem data mask gates all other otmem flags onto the pin.
// - The fault link detected flag pulls the pin low while its mask bit is 0.
// - The fault tone detected flag pulls the pin low while its mask bit is 0.
// - Heartbeat too fast or lost pulls the pin low while the heartbeat mask is 0.
// - Any chain link fault pulls the pin low while the chain link mask is 0.
// - Any uart link fault pulls the pin low while the uart link mask is 0.
// - Writing 1 to the guard clear bit clears both guard status registers.
// - Writing 1 to a temp, volt or adc compare clear bit clears that whole group.
// - System and rail clear bits clear their groups and then drop back to 0 alone.
// - Otmem crc clear hits only the crc flags, otmem data clear only the error flags.
// - Link detect, tone and heartbeat clears hit only their own link flags.
// - Chain and uart link clears also clear their debug registers.
// - A read-only summary register mirrors the masked conditions of the alarm pin.
module fault_mask_and_clear
  import fault_mask_and_clear_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  // register port
  input wire reg_addr_type reg_addr,
  input wire reg_byte_type reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output reg_byte_type reg_rdata,
  // group status levels
  input wire logic guard_any,
  input wire logic undertemp_any,
  input wire logic overtemp_any,
  input wire logic undervolt_any,
  input wire logic overvolt_any,
  input wire logic adc_compare_any,
  input wire logic system_any,
  input wire logic rail_any,
  input wire logic customer_crc_error,
  input wire logic factory_crc_error,
  input wire logic otmem_data_any,
  input wire logic fault_link_detected,
  input wire logic fault_tone_detected,
  input wire logic heartbeat_too_fast,
  input wire logic heartbeat_lost,
  input wire logic chain_link_any,
  input wire logic uart_link_any,
  // clear pulses to status owners
  output logic guard_group_clear,
  output logic undertemp_clear,
  output logic overtemp_clear,
  output logic undervolt_clear,
  output logic overvolt_clear,
  output logic adc_compare_clear,
  output logic system_group_clear,
  output logic rail_group_clear,
  output logic otmem_crc_clear,
  output logic otmem_data_clear,
  output logic fault_link_detect_clear,
  output logic fault_tone_clear,
  output logic heartbeat_clear,
  output logic chain_link_clear,
  output logic uart_link_clear,
  // alarm pin and interrupt
  output logic alarm_out_n,
  output logic irq
);

  function automatic logic addr_hit(input reg_addr_type a, input reg_addr_type ofs);
    addr_hit = (a == ofs);
  endfunction

  // summary slot that each masked lane feeds
  function automatic int unsigned summary_slot(input int unsigned lane);
    unique case (lane)
      14: summary_slot = `FMC_SUM_GUARD;
      13: summary_slot = `FMC_SUM_TEMP;
      12: summary_slot = `FMC_SUM_TEMP;
      11: summary_slot = `FMC_SUM_VOLT;
      10: summary_slot = `FMC_SUM_VOLT;
      9: summary_slot = `FMC_SUM_ADC_COMPARE;
      8: summary_slot = `FMC_SUM_SYSTEM;
      7: summary_slot = `FMC_SUM_RAIL;
      6: summary_slot = `FMC_SUM_OTMEM;
      5: summary_slot = `FMC_SUM_OTMEM;
      4: summary_slot = `FMC_SUM_LINK;
      3: summary_slot = `FMC_SUM_LINK;
      2: summary_slot = `FMC_SUM_LINK;
      1: summary_slot = `FMC_SUM_LINK;
      0: summary_slot = `FMC_SUM_LINK;
      default: summary_slot = `FMC_SUM_RAIL;
    endcase
  endfunction

  reg_byte_type mask_primary_ff;
  reg_byte_type mask_secondary_ff;
  reg_byte_type clear_primary_ff;
  reg_byte_type clear_secondary_ff;
  reg_byte_type irq_status_ff;
  reg_byte_type irq_mask_ff;
  reg_byte_type summary_prev_ff;
  reg_byte_type rdata_ff;
  logic alarm_n_ff;
  reg_byte_type alarm_summary;
  reg_byte_type nxt_rdata;
  reg_byte_type summary_rise;
  logic wr_mask_primary;
  logic wr_mask_secondary;
  logic wr_clear_primary;
  logic wr_clear_secondary;
  logic wr_irq_mask;
  logic rd_irq_status;
  logic [14:0] lane_level;
  logic [14:0] lane_mask;
  logic [14:0] lane_hit;

  assign wr_mask_primary = reg_wr && addr_hit(reg_addr, `FMC_OFS_MASK_PRIMARY);
  assign wr_mask_secondary = reg_wr && addr_hit(reg_addr, `FMC_OFS_MASK_SECONDARY);
  assign wr_clear_primary = reg_wr && addr_hit(reg_addr, `FMC_OFS_CLEAR_PRIMARY);
  assign wr_clear_secondary = reg_wr && addr_hit(reg_addr, `FMC_OFS_CLEAR_SECONDARY);
  assign wr_irq_mask = reg_wr && addr_hit(reg_addr, `FMC_OFS_IRQ_MASK);
  assign rd_irq_status = reg_rd && addr_hit(reg_addr, `FMC_OFS_IRQ_STATUS);

  // mask registers, spare bit stored but never read by logic
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mask_primary_ff <= `FMC_RST_MASK_PRIMARY;
    end else if (wr_mask_primary) begin
      mask_primary_ff <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mask_secondary_ff <= `FMC_RST_MASK_SECONDARY;
    end else if (wr_mask_secondary) begin
      mask_secondary_ff <= reg_wdata;
    end
  end

  // write-one clear bits: held one cycle, then back to 0 by themselves
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      clear_primary_ff <= `FMC_RST_CLEAR;
    end else if (wr_clear_primary) begin
      clear_primary_ff <= reg_wdata & `FMC_CLEAR_PRIMARY_BITS;
    end else begin
      clear_primary_ff <= `FMC_RST_CLEAR;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      clear_secondary_ff <= `FMC_RST_CLEAR;
    end else if (wr_clear_secondary) begin
      clear_secondary_ff <= reg_wdata & `FMC_CLEAR_SECONDARY_BITS;
    end else begin
      clear_secondary_ff <= `FMC_RST_CLEAR;
    end
  end

  // every set bit except secondary bit 7 pulses together, zeros pulse nothing
  assign guard_group_clear = clear_primary_ff[`FMC_P_GUARD];
  assign undertemp_clear = clear_primary_ff[`FMC_P_UNDERTEMP];
  assign overtemp_clear = clear_primary_ff[`FMC_P_OVERTEMP];
  assign undervolt_clear = clear_primary_ff[`FMC_P_UNDERVOLT];
  assign overvolt_clear = clear_primary_ff[`FMC_P_OVERVOLT];
  assign adc_compare_clear = clear_primary_ff[`FMC_P_ADC_COMPARE];
  assign system_group_clear = clear_primary_ff[`FMC_P_SYSTEM];
  assign rail_group_clear = clear_primary_ff[`FMC_P_RAIL];
  assign otmem_crc_clear = clear_secondary_ff[`FMC_S_OTMEM_CRC];
  assign otmem_data_clear = clear_secondary_ff[`FMC_S_OTMEM_DATA];
  assign fault_link_detect_clear = clear_secondary_ff[`FMC_S_FAULT_LINK];
  assign fault_tone_clear = clear_secondary_ff[`FMC_S_FAULT_TONE];
  assign heartbeat_clear = clear_secondary_ff[`FMC_S_HEARTBEAT];
  assign chain_link_clear = clear_secondary_ff[`FMC_S_CHAIN_LINK];
  assign uart_link_clear = clear_secondary_ff[`FMC_S_UART_LINK];

  // raw levels, lane order follows the two mask registers
  assign lane_level[14] = guard_any;
  assign lane_level[13] = undertemp_any;
  assign lane_level[12] = overtemp_any;
  assign lane_level[11] = undervolt_any;
  assign lane_level[10] = overvolt_any;
  assign lane_level[9] = adc_compare_any;
  assign lane_level[8] = system_any;
  assign lane_level[7] = rail_any;
  assign lane_level[6] = customer_crc_error || factory_crc_error;
  assign lane_level[5] = otmem_data_any;
  assign lane_level[4] = fault_link_detected;
  assign lane_level[3] = fault_tone_detected;
  assign lane_level[2] = heartbeat_too_fast || heartbeat_lost;
  assign lane_level[1] = chain_link_any;
  assign lane_level[0] = uart_link_any;

  // mask bit of each lane
  assign lane_mask[14] = mask_primary_ff[`FMC_P_GUARD];
  assign lane_mask[13] = mask_primary_ff[`FMC_P_UNDERTEMP];
  assign lane_mask[12] = mask_primary_ff[`FMC_P_OVERTEMP];
  assign lane_mask[11] = mask_primary_ff[`FMC_P_UNDERVOLT];
  assign lane_mask[10] = mask_primary_ff[`FMC_P_OVERVOLT];
  assign lane_mask[9] = mask_primary_ff[`FMC_P_ADC_COMPARE];
  assign lane_mask[8] = mask_primary_ff[`FMC_P_SYSTEM];
  assign lane_mask[7] = mask_primary_ff[`FMC_P_RAIL];
  assign lane_mask[6] = mask_secondary_ff[`FMC_S_OTMEM_CRC];
  assign lane_mask[5] = mask_secondary_ff[`FMC_S_OTMEM_DATA];
  assign lane_mask[4] = mask_secondary_ff[`FMC_S_FAULT_LINK];
  assign lane_mask[3] = mask_secondary_ff[`FMC_S_FAULT_TONE];
  assign lane_mask[2] = mask_secondary_ff[`FMC_S_HEARTBEAT];
  assign lane_mask[1] = mask_secondary_ff[`FMC_S_CHAIN_LINK];
  assign lane_mask[0] = mask_secondary_ff[`FMC_S_UART_LINK];

  // a set mask bit keeps its lane away from pin and summary
  genvar lane_i;
  generate
    for (lane_i = 0; lane_i < 15; lane_i++) begin : g_lane
      assign lane_hit[lane_i] = lane_level[lane_i] && !lane_mask[lane_i];
    end
  endgenerate

  // per-group summary, shared by pin and summary register
  always_comb begin
    alarm_summary = 8'h00;
    for (int unsigned i = 0; i < 15; i++) begin
      if (lane_hit[i]) begin
        alarm_summary[summary_slot(i)] = 1'h1;
      end
    end
  end

  // alarm pin, low while any masked condition holds
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      alarm_n_ff <= 1'h1;
    end else begin
      alarm_n_ff <= ~|alarm_summary;
    end
  end

  assign alarm_out_n = alarm_n_ff;

  // interrupt: rising summary bits are sticky, a status read clears
  assign summary_rise = alarm_summary & ~summary_prev_ff;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      summary_prev_ff <= 8'h00;
    end else begin
      summary_prev_ff <= alarm_summary;
    end
  end

  // each status bit is sticky on its own; a new event in the read cycle survives
  genvar slot_i;
  generate
    for (slot_i = 0; slot_i < 8; slot_i++) begin : g_status
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          irq_status_ff[slot_i] <= `FMC_RST_IRQ_STATUS_BIT;
        end else if (rd_irq_status) begin
          irq_status_ff[slot_i] <= summary_rise[slot_i];
        end else begin
          irq_status_ff[slot_i] <= irq_status_ff[slot_i] | summary_rise[slot_i];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_mask_ff <= `FMC_RST_IRQ_MASK;
    end else if (wr_irq_mask) begin
      irq_mask_ff <= reg_wdata;
    end
  end

  assign irq = |(irq_status_ff & ~irq_mask_ff);

  // read mux, unmapped addresses read 0
  always_comb begin
    nxt_rdata = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        `FMC_OFS_MASK_PRIMARY: nxt_rdata = mask_primary_ff;
        `FMC_OFS_MASK_SECONDARY: nxt_rdata = mask_secondary_ff;
        `FMC_OFS_CLEAR_PRIMARY: nxt_rdata = clear_primary_ff;
        `FMC_OFS_CLEAR_SECONDARY: nxt_rdata = clear_secondary_ff;
        `FMC_OFS_ALARM_SUMMARY: nxt_rdata = alarm_summary;
        `FMC_OFS_IRQ_STATUS: nxt_rdata = irq_status_ff;
        `FMC_OFS_IRQ_MASK: nxt_rdata = irq_mask_ff;
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_ff <= `FMC_RST_READ_DATA;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

endmodule // fault_mask_and_clear

// ### fault_mask_and_clear_properties.sv
// checker: alarm pin, clear pulses and mask readback of the fault block
// assumes one clk domain with async active-low nrst
`timescale 1ns/1ps
module fault_mask_and_clear_properties
  import fault_mask_and_clear_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire reg_addr_type reg_addr,
  input wire reg_byte_type reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire reg_byte_type reg_rdata,
  input wire logic guard_any,
  input wire logic system_any,
  input wire logic customer_crc_error,
  input wire logic factory_crc_error,
  input wire logic heartbeat_too_fast,
  input wire logic heartbeat_lost,
  input wire logic chain_link_any,
  input wire logic guard_group_clear,
  input wire logic undertemp_clear,
  input wire logic overtemp_clear,
  input wire logic undervolt_clear,
  input wire logic overvolt_clear,
  input wire logic adc_compare_clear,
  input wire logic system_group_clear,
  input wire logic rail_group_clear,
  input wire logic otmem_crc_clear,
  input wire logic otmem_data_clear,
  input wire logic heartbeat_clear,
  input wire logic alarm_out_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic [7:0] mask1_ff;
  logic [7:0] mask2_ff;
  logic [7:0] clr1;
  logic wr1;
  // shadow of the two mask registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mask1_ff <= 8'h00;
      mask2_ff <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == 12'h016) mask1_ff <= reg_wdata;
      if (reg_addr == 12'h017) mask2_ff <= reg_wdata;
    end
  end
  assign clr1 = {guard_group_clear, undertemp_clear, overtemp_clear, undervolt_clear,
    overvolt_clear, adc_compare_clear, system_group_clear, rail_group_clear};
  assign wr1 = reg_wr && reg_addr == 12'h331;
  AST_GUARD_ALARM: assert property (!mask1_ff[7] && guard_any |=> !alarm_out_n)
    else $error("guard fault did not pull alarm low");
  AST_SYSTEM_ALARM: assert property (!mask1_ff[1] && system_any |=> !alarm_out_n)
    else $error("system fault did not pull alarm low");
  AST_CRC_ALARM: assert property (!mask2_ff[6] && (customer_crc_error ||
    factory_crc_error) |=> !alarm_out_n) else $error("crc flag did not pull alarm low");
  AST_HB_ALARM: assert property (!mask2_ff[2] && (heartbeat_too_fast ||
    heartbeat_lost) |=> !alarm_out_n) else $error("heartbeat flag did not pull alarm low");
  AST_CHAIN_ALARM: assert property (!mask2_ff[1] && chain_link_any |=> !alarm_out_n)
    else $error("chain link fault did not pull alarm low");
  AST_CLEAR_PRIMARY: assert property (wr1 |=> clr1 == $past(reg_wdata))
    else $error("primary clear pulses differ from written bits");
  AST_PRIMARY_SELF_CLEAR: assert property (!wr1 |=> clr1 == 8'h00)
    else $error("primary clear pulse without a write");
  AST_OTMEM_CLEARS: assert property (reg_wr && reg_addr == 12'h332 |=>
    {otmem_crc_clear, otmem_data_clear} == $past(reg_wdata[6:5]))
    else $error("otmem clear pulses differ from written bits");
  AST_HB_CLEAR: assert property (reg_wr && reg_addr == 12'h332 |=>
    heartbeat_clear == $past(reg_wdata[2])) else $error("heartbeat clear pulse wrong");
  AST_MASK_READBACK: assert property (reg_rd && reg_addr == 12'h016 |=>
    reg_rdata == mask1_ff) else $error("primary mask read back wrong");
  cover property (!alarm_out_n ##1 alarm_out_n);
  cover property (wr1 && reg_wdata == 8'hFF);
  cover property (mask1_ff[7] && guard_any);
endmodule // fault_mask_and_clear_properties

bind fault_mask_and_clear fault_mask_and_clear_properties chk_u (.*);

// ### host_alarm_watch.sv
// host controller model: counts falling edges of the alarm pin
// assumes the block clock and reset
`timescale 1ns/1ps
module host_alarm_watch (
  input wire logic clk,
  input wire logic nrst,
  input wire logic alarm_out_n,
  output logic [7:0] alarm_count
);
  logic level_ff;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      level_ff <= 1'b1;
      alarm_count <= 8'h00;
    end else begin
      level_ff <= alarm_out_n;
      if (level_ff && !alarm_out_n) alarm_count <= alarm_count + 8'h01;
    end
  end
endmodule // host_alarm_watch

// ### tb_fault_mask_and_clear.sv
// self-checking bench of the fault block through its register port
// assumes 10 MHz clk, nrst low for 12 cycles, host watch model
`timescale 1ns/1ps
module tb_fault_mask_and_clear
  import fault_mask_and_clear_pkg::*;
;
  logic clk, nrst, reg_wr, reg_rd, irq, alarm_out_n;
  reg_addr_type reg_addr;
  reg_byte_type reg_wdata, reg_rdata;
  logic guard_any, undertemp_any, overtemp_any, undervolt_any, overvolt_any, adc_compare_any;
  logic system_any, rail_any, customer_crc_error, factory_crc_error, otmem_data_any;
  logic fault_link_detected, fault_tone_detected, heartbeat_too_fast, heartbeat_lost;
  logic chain_link_any, uart_link_any, guard_group_clear, undertemp_clear, overtemp_clear;
  logic undervolt_clear, overvolt_clear, adc_compare_clear, system_group_clear;
  logic rail_group_clear, otmem_crc_clear, otmem_data_clear, fault_link_detect_clear;
  logic fault_tone_clear, heartbeat_clear, chain_link_clear, uart_link_clear;
  logic [7:0] alarm_count;
  logic [16:0] flt;
  logic [14:0] clr;
  int miscompares, compares;
  int mb[17] = '{7, 6, 5, 4, 3, 2, 1, 0, 14, 14, 13, 12, 11, 10, 10, 9, 8};
  int sb[17] = '{7, 3, 3, 2, 2, 6, 1, 0, 5, 5, 5, 4, 4, 4, 4, 4, 4};
  reg_addr_type ofs[7] = '{12'h016, 12'h017, 12'h331, 12'h332, 12'h52D, 12'h601, 12'h123};
  reg_addr_type ca[6] = '{12'h331, 12'h331, 12'h331, 12'h332, 12'h332, 12'h332};
  reg_byte_type cd[6] = '{8'hFF, 8'h00, 8'h81, 8'hFF, 8'h80, 8'h55};
  logic [14:0] ce[6] = '{15'h7F80, 15'h0000, 15'h4080, 15'h007F, 15'h0000, 15'h0055};
  reg_addr_type ma;
  reg_byte_type spare;
  fault_mask_and_clear dut_u (.*);
  host_alarm_watch host_u (.*);
  assign {guard_any, undertemp_any, overtemp_any, undervolt_any, overvolt_any, adc_compare_any,
    system_any, rail_any, customer_crc_error, factory_crc_error, otmem_data_any,
    fault_link_detected, fault_tone_detected, heartbeat_too_fast, heartbeat_lost,
    chain_link_any, uart_link_any} = flt;
  assign clr = {guard_group_clear, undertemp_clear, overtemp_clear, undervolt_clear,
    overvolt_clear, adc_compare_clear, system_group_clear, rail_group_clear, otmem_crc_clear,
    otmem_data_clear, fault_link_detect_clear, fault_tone_clear, heartbeat_clear,
    chain_link_clear, uart_link_clear};
  task automatic check(input logic [15:0] seen, input logic [15:0] want, input string what);
    compares++;
    if (seen !== want) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic wr(input reg_addr_type a, input reg_byte_type d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input reg_addr_type a, input reg_byte_type want);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check(16'(reg_rdata), 16'(want), "reg_rdata");
  endtask
  task automatic setf(input logic [16:0] v);
    @(posedge clk);
    flt <= v;
  endtask
  task automatic conclude();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #200000;
    miscompares++;
    conclude();
  end
  initial begin
    nrst = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 12'h000;
    reg_wdata = 8'h00;
    flt = 17'h00000;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    foreach (ofs[i]) rd(ofs[i], 8'h00);
    wr(12'h016, 8'hA5);
    wr(12'h123, 8'hFF);
    rd(12'h016, 8'hA5);
    wr(12'h016, 8'h00);
    wr(12'h017, 8'h80);
    for (int i = 0; i < 17; i++) begin
      ma = mb[i] > 7 ? 12'h017 : 12'h016;
      spare = mb[i] > 7 ? 8'h80 : 8'h00;
      setf(17'h10000 >> i);
      repeat (2) @(posedge clk);
      #1;
      check(16'(alarm_out_n), 16'h0000, "alarm_out_n");
      check(16'(irq), 16'h0001, "irq");
      rd(12'h52D, 8'(1 << sb[i]));
      rd(12'h600, 8'(1 << sb[i]));
      check(16'(irq), 16'h0000, "irq");
      wr(ma, 8'(1 << mb[i][2:0]) | spare);
      @(posedge clk);
      #1;
      check(16'(alarm_out_n), 16'h0001, "alarm_out_n");
      rd(12'h52D, 8'h00);
      setf(17'h00000);
      wr(ma, spare);
    end
    wr(12'h601, 8'h80);
    setf(17'h10000);
    repeat (2) @(posedge clk);
    #1;
    check(16'(irq), 16'h0000, "irq");
    rd(12'h600, 8'h80);
    setf(17'h00000);
    wr(12'h601, 8'h00);
    for (int i = 0; i < 6; i++) begin
      wr(ca[i], cd[i]);
      check(16'(clr), 16'(ce[i]), "clear pulses");
      rd(ca[i], 8'h00);
    end
    check(16'(alarm_count), 16'h0012, "alarm_count");
    wr(12'h016, 8'hFF);
    @(posedge clk);
    nrst <= 1'b0;
    @(posedge clk);
    nrst <= 1'b1;
    rd(12'h016, 8'h00);
    conclude();
  end
endmodule // tb_fault_mask_and_clear
